// file: core_timing_defines.vh
`ifndef CORE_TIMING_DEFINES_VH
`define CORE_TIMING_DEFINES_VH

// ==================================================
// Opcode encodings with special meaning
`define OPC_NOP 8'h00
`define OPC_SPARE 8'hA5

// ==================================================
// Instruction lengths in program bytes
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3

// ==================================================
// Latencies in system clock cycles
`define CYC_NONE 4'h0
`define CYC_ONE 4'h1
`define CYC_FLOW_EXTRA 4'h1
`define CYC_TAKEN_EXTRA 4'h1
`define CYC_MUL 4'h4
`define CYC_DIV 4'h8
`define CYC_RETURN 4'h5
`define CYC_MEM_XFER 4'h3

// ==================================================
// Direct operand space split
`define SFR_SELECT_BIT 7

// ==================================================
// Reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000

`endif

// file: cpu_instruction_timing.v
// Overview of operation
// - Standard opcode map, encodings and addressing kept
// - Latency counted in clocks, no machine cycles
// - Default latency equals instruction byte count
// - Untaken conditional branch one clock shorter
// - Arithmetic: register 1, memory 2, multiply 4, divide 8
// - Data pointer increment: one byte, one clock
// - Logic ops 1/2 clocks, immediate-to-direct 3
// - Accumulator single-byte ops take one clock
// - Register moves 1, indirect RAM write 2
// - Direct-direct and immediate-direct moves: 3 clocks
// - Direct to/from indirect RAM: 2 clocks
// - Data pointer immediate load: 3 bytes, 3 clocks
// - Code byte move: one byte, 3 clocks
// - External data moves: one byte, 3 clocks
// - Push and pop direct: 2 bytes, 2 clocks
// - Conditional jumps 2/3, 3/4, indirect compare 4/5
// - Relative target: next instruction plus signed offset
// - Direct 00-7F is RAM, 80-FF is SFR
// - Spare opcode behaves as one-byte no-op
`timescale 1ns/1ps
`default_nettype none
`include "core_timing_defines.vh"

module cpu_instruction_timing #(
  parameter CNT_W = 4
) (
  input wire clock,
  input wire reset_n,
  input wire fetch_valid,
  input wire [7:0] fetch_opcode,
  input wire [7:0] fetch_byte2,
  input wire [7:0] fetch_byte3,
  input wire [15:0] fetch_pc,
  input wire branch_cond,
  output wire issue_ready,
  output wire instr_busy,
  output wire instr_done,
  output reg [1:0] instr_len_q,
  output reg [CNT_W-1:0] instr_cycles_q,
  output reg cond_branch_q,
  output reg branch_taken_q,
  output reg rel_valid_q,
  output reg [15:0] branch_target_q,
  output reg direct_valid_q,
  output reg direct_is_sfr_q,
  output reg [7:0] direct_addr_q,
  output reg noop_q
);

  // ==================================================
  // Opcode decode
  wire [3:0] hi = fetch_opcode[7:4];
  wire [3:0] lo = fetch_opcode[3:0];
  reg [1:0] dec_len;
  reg [3:0] dec_fixed;
  reg [3:0] dec_extra;
  reg dec_cond;
  reg dec_rel;
  reg dec_dir;
  reg dec_noop;

  // Length and latency per opcode; fixed overrides length-based count
  always @* begin
    dec_len = `LEN_1;
    dec_fixed = `CYC_NONE;
    dec_extra = `CYC_NONE;
    dec_cond = 1'b0;
    dec_rel = 1'b0;
    dec_dir = 1'b0;
    dec_noop = 1'b0;
    if (lo[3]) begin
      // Bank register column
      case (hi)
        4'h7: dec_len = `LEN_2;
        4'h8, 4'hA: begin
          dec_len = `LEN_2;
          dec_dir = 1'b1;
        end
        4'hB: begin
          dec_len = `LEN_3;
          dec_cond = 1'b1;
          dec_rel = 1'b1;
        end
        4'hD: begin
          dec_len = `LEN_2;
          dec_cond = 1'b1;
          dec_rel = 1'b1;
        end
        default: dec_len = `LEN_1;
      endcase
    end else if (lo[3:1] == 3'h3) begin
      // Pointer register indirect column
      case (hi)
        4'h7: dec_len = `LEN_2;
        4'h8, 4'hA: begin
          dec_len = `LEN_2;
          dec_dir = 1'b1;
        end
        4'hB: begin
          dec_len = `LEN_3; // Indirect compare 4/5
          dec_extra = `CYC_FLOW_EXTRA;
          dec_cond = 1'b1;
          dec_rel = 1'b1;
        end
        default: dec_extra = `CYC_FLOW_EXTRA; // RAM access costs a clock
      endcase
    end else begin
      case (lo)
        4'h5: begin
          dec_len = `LEN_2;
          dec_dir = 1'b1;
          case (hi)
            4'h7, 4'h8: dec_len = `LEN_3;
            4'hA: begin
              dec_len = `LEN_1; // Spare opcode, no effect
              dec_dir = 1'b0;
              dec_noop = 1'b1;
            end
            4'hB, 4'hD: begin
              dec_len = `LEN_3;
              dec_cond = 1'b1;
              dec_rel = 1'b1;
            end
            default: dec_len = `LEN_2;
          endcase
        end
        4'h4: begin
          case (hi)
            4'h8: dec_fixed = `CYC_DIV;
            4'hA: dec_fixed = `CYC_MUL;
            4'hB: begin
              dec_len = `LEN_3;
              dec_cond = 1'b1;
              dec_rel = 1'b1;
            end
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: dec_len = `LEN_2;
            default: dec_len = `LEN_1;
          endcase
        end
        4'h3: begin
          case (hi)
            4'h4, 4'h5, 4'h6: begin
              dec_len = `LEN_3;
              dec_dir = 1'b1;
            end
            4'h7, 4'h8, 4'h9, 4'hE, 4'hF: dec_fixed = `CYC_MEM_XFER;
            default: dec_len = `LEN_1;
          endcase
        end
        4'h2: begin
          case (hi)
            4'h0, 4'h1: begin
              dec_len = `LEN_3;
              dec_extra = `CYC_FLOW_EXTRA;
            end
            4'h2, 4'h3: dec_fixed = `CYC_RETURN;
            4'h4, 4'h5, 4'h6: begin
              dec_len = `LEN_2;
              dec_dir = 1'b1;
            end
            4'hE, 4'hF: dec_fixed = `CYC_MEM_XFER;
            default: dec_len = `LEN_2;
          endcase
        end
        4'h1: begin
          dec_len = `LEN_2;
          dec_extra = `CYC_FLOW_EXTRA;
        end
        default: begin
          case (hi)
            4'h0: dec_noop = 1'b1;
            4'h1, 4'h2, 4'h3: begin
              dec_len = `LEN_3;
              dec_cond = 1'b1;
              dec_rel = 1'b1;
            end
            4'h4, 4'h5, 4'h6, 4'h7: begin
              dec_len = `LEN_2;
              dec_cond = 1'b1;
              dec_rel = 1'b1;
            end
            4'h8: begin
              dec_len = `LEN_2;
              dec_extra = `CYC_FLOW_EXTRA;
              dec_rel = 1'b1;
            end
            4'h9: dec_len = `LEN_3;
            4'hC, 4'hD: begin
              dec_len = `LEN_2;
              dec_dir = 1'b1;
            end
            4'hE, 4'hF: dec_fixed = `CYC_MEM_XFER;
            default: dec_len = `LEN_2;
          endcase
        end
      endcase
    end
  end

  // ==================================================
  // Latency selection
  wire [3:0] base_cycles = (dec_fixed != `CYC_NONE) ? dec_fixed : ({2'h0, dec_len} + dec_extra);
  wire taken = dec_cond && branch_cond;
  // Taken branch costs one more clock than falling through
  wire [3:0] sel_cycles = base_cycles + (taken ? `CYC_TAKEN_EXTRA : `CYC_NONE);
  wire issue = fetch_valid && issue_ready;

  // ==================================================
  // Relative target: offset is the last byte of the instruction
  wire [7:0] rel_byte = (dec_len == `LEN_3) ? fetch_byte3 : fetch_byte2;
  wire [15:0] next_pc = fetch_pc + {14'h0, dec_len};
  wire [15:0] target = next_pc + {{8{rel_byte[7]}}, rel_byte};

  instr_cycle_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .clock(clock),
    .reset_n(reset_n),
    .load(issue),
    .load_count(sel_cycles[CNT_W-1:0]),
    .busy_q(instr_busy),
    .done_q(instr_done),
    .ready_q(issue_ready)
  );

  // Decoded fields held for the life of the instruction
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      instr_len_q <= 2'h0;
      instr_cycles_q <= {CNT_W{1'b0}};
      cond_branch_q <= 1'b0;
      branch_taken_q <= 1'b0;
      rel_valid_q <= 1'b0;
      branch_target_q <= `RST_WORD;
      direct_valid_q <= 1'b0;
      direct_is_sfr_q <= 1'b0;
      direct_addr_q <= `RST_BYTE;
      noop_q <= 1'b0;
    end else if (issue) begin
      instr_len_q <= dec_len;
      instr_cycles_q <= sel_cycles[CNT_W-1:0];
      cond_branch_q <= dec_cond;
      branch_taken_q <= taken;
      rel_valid_q <= dec_rel;
      branch_target_q <= dec_rel ? target : next_pc;
      direct_valid_q <= dec_dir;
      direct_is_sfr_q <= dec_dir && fetch_byte2[`SFR_SELECT_BIT]; // Upper half is SFR space
      direct_addr_q <= fetch_byte2;
      noop_q <= dec_noop || (fetch_opcode == `OPC_SPARE) || (fetch_opcode == `OPC_NOP);
    end
  end

endmodule // cpu_instruction_timing

`default_nettype wire

// file: instr_cycle_counter.v
`timescale 1ns/1ps
`default_nettype none

// ==================================================
// Cycle down-counter: busy for exactly the loaded number of clocks
module instr_cycle_counter #(
  parameter CNT_W = 4
) (
  input wire clock,
  input wire reset_n,
  input wire load,
  input wire [CNT_W-1:0] load_count,
  output reg busy_q,
  output reg done_q,
  output reg ready_q
);

  reg [CNT_W-1:0] count_q;
  reg [CNT_W-1:0] count_d;
  reg busy_d;
  reg done_d;

  // Next state; a reload in the last cycle gives back-to-back issue
  always @* begin
    count_d = count_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (load) begin
      count_d = load_count - {{(CNT_W-1){1'b0}}, 1'b1};
      busy_d = 1'b1;
      done_d = (load_count == {{(CNT_W-1){1'b0}}, 1'b1});
    end else if (busy_q) begin
      if (count_q == {CNT_W{1'b0}}) begin
        busy_d = 1'b0;
      end else begin
        count_d = count_q - {{(CNT_W-1){1'b0}}, 1'b1};
        done_d = (count_q == {{(CNT_W-1){1'b0}}, 1'b1});
      end
    end
  end

  // Counting in plain clocks, no machine-cycle grouping
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= {CNT_W{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      count_q <= count_d;
      busy_q <= busy_d;
      done_q <= done_d;
      ready_q <= !busy_d || (count_d == {CNT_W{1'b0}});
    end
  end

endmodule // instr_cycle_counter

`default_nettype wire

// file: instr_timing_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ==========
// Port checker for the timing decoder
module instr_timing_sva #(
  parameter CNT_W = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_opcode,
  input wire logic branch_cond,
  input wire logic issue_ready,
  input wire logic instr_busy,
  input wire logic instr_done,
  input wire logic [1:0] instr_len_q,
  input wire logic [CNT_W-1:0] instr_cycles_q,
  input wire logic branch_taken_q,
  input wire logic direct_is_sfr_q,
  input wire logic direct_valid_q,
  input wire logic [7:0] direct_addr_q,
  input wire logic noop_q
);
  wire take;

  // Accepted issue: request while ready
  assign take = fetch_valid && issue_ready;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_busy_follows: assert property (take |=> instr_busy) else $error("busy missing after issue");
  a_done_ready_tie: assert property (instr_busy |-> instr_done == issue_ready) else $error("done and ready apart");
  a_idle_ready: assert property (!instr_busy |-> issue_ready && !instr_done) else $error("idle but not ready");
  a_divide_eight: assert property (take && fetch_opcode == 8'h84 |=>
    (instr_cycles_q == 4'h8 && !instr_done) [*7] ##1 instr_done) else $error("divide not eight clocks");
  a_multiply_four: assert property (take && fetch_opcode == 8'hA4 |=>
    (!instr_done) [*3] ##1 instr_done) else $error("multiply not four clocks");
  a_untaken_short: assert property (take && fetch_opcode == 8'h60 && !branch_cond |=>
    instr_cycles_q == 4'h2 && !branch_taken_q) else $error("untaken jump not two clocks");
  a_taken_long: assert property (take && fetch_opcode == 8'h60 && branch_cond |=>
    instr_cycles_q == 4'h3 && branch_taken_q) else $error("taken jump not three clocks");
  a_pointer_inc: assert property (take && fetch_opcode == 8'hA3 |=> instr_len_q == 2'h1 && instr_done)
    else $error("pointer increment not one clock");
  a_spare_noop: assert property (take && fetch_opcode == 8'hA5 |=> noop_q && instr_done)
    else $error("spare opcode not a no-op");
  a_sfr_split: assert property (direct_valid_q |-> direct_is_sfr_q == direct_addr_q[7])
    else $error("direct space split wrong");
  a_refuse_hold: assert property (instr_busy && !issue_ready |=> $stable(instr_cycles_q))
    else $error("request taken while busy");

  // Main scenarios reached
  c_divide: cover property (take && fetch_opcode == 8'h84);
  c_taken: cover property (branch_taken_q);
  c_back_to_back: cover property (instr_done && take);
endmodule // instr_timing_sva

bind cpu_instruction_timing instr_timing_sva #(.CNT_W(CNT_W)) sva_i (
  .clock(clock), .reset_n(reset_n), .fetch_valid(fetch_valid), .fetch_opcode(fetch_opcode),
  .branch_cond(branch_cond), .issue_ready(issue_ready), .instr_busy(instr_busy), .instr_done(instr_done),
  .instr_len_q(instr_len_q), .instr_cycles_q(instr_cycles_q), .branch_taken_q(branch_taken_q),
  .direct_is_sfr_q(direct_is_sfr_q), .direct_valid_q(direct_valid_q), .direct_addr_q(direct_addr_q),
  .noop_q(noop_q)
);

`default_nettype wire

// file: prog_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========
// Program memory seen by the decoder
module prog_mem_model (
  input wire logic [15:0] addr,
  output logic [7:0] op,
  output logic [7:0] b2,
  output logic [7:0] b3
);
  logic [7:0] mem [0:256-1];

  // Unwritten bytes hold the inverted address, so a stray fetch reads as a clean zero only at address FF
  initial for (int i = 0; i < 256; i++) mem[i] = 8'hFF ^ i[7:0];

  // Instruction bytes in parallel; the address wraps inside the small array
  assign op = mem[addr[7:0]];
  assign b2 = mem[addr[7:0] + 8'h01];
  assign b3 = mem[addr[7:0] + 8'h02];
endmodule // prog_mem_model

`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clock = 1'b0, reset_n = 1'b0, fetch_valid = 1'b0, branch_cond = 1'b0;
  logic [15:0] fetch_pc = 16'h0000, pc = 16'h0010;
  wire [7:0] op, b2, b3, direct_addr_q;
  wire issue_ready, instr_busy, instr_done, branch_taken_q, direct_is_sfr_q, noop_q;
  wire cond_branch_q, rel_valid_q;
  wire [1:0] instr_len_q;
  wire [3:0] instr_cycles_q;
  wire [15:0] branch_target_q;
  int n_mismatch = 0, check_count = 0;

  // 25 MHz clock
  always #20 clock = ~clock;

  // ==========
  // Instances
  prog_mem_model mem_i (.addr(fetch_pc), .op(op), .b2(b2), .b3(b3));
  cpu_instruction_timing #(.CNT_W(4)) dut (.clock(clock), .reset_n(reset_n), .fetch_valid(fetch_valid),
    .fetch_opcode(op), .fetch_byte2(b2), .fetch_byte3(b3), .fetch_pc(fetch_pc), .branch_cond(branch_cond),
    .issue_ready(issue_ready), .instr_busy(instr_busy), .instr_done(instr_done), .instr_len_q(instr_len_q),
    .instr_cycles_q(instr_cycles_q), .cond_branch_q(cond_branch_q), .branch_taken_q(branch_taken_q),
    .rel_valid_q(rel_valid_q),
    .branch_target_q(branch_target_q), .direct_valid_q(), .direct_is_sfr_q(direct_is_sfr_q),
    .direct_addr_q(direct_addr_q), .noop_q(noop_q));

  // ==========
  // Shared tasks
  task automatic conclude;
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (e !== g) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Place one instruction at pc, issue it, count busy clocks and where done fell
  task automatic run(input logic [7:0] o, x, y, input logic c, output int n, output int d);
    int k;
    mem_i.mem[pc[7:0]] = o;
    mem_i.mem[pc[7:0] + 8'h01] = x;
    mem_i.mem[pc[7:0] + 8'h02] = y;
    fetch_pc = pc;
    branch_cond = c;
    fetch_valid = 1'b1;
    k = 0;
    d = 0;
    while (issue_ready !== 1'b1 && k < 20) begin @(posedge clock); #1; k++; end
    @(posedge clock);
    #1;
    fetch_valid = 1'b0;
    n = 0;
    while (instr_busy === 1'b1 && n < 20) begin
      n++;
      if (instr_done === 1'b1) d = n;
      @(posedge clock);
      #1;
    end
    if (k == 20 || n == 20) begin n_mismatch++; conclude(); end
  endtask

  // ==========
  // Scenarios
  // Rows are opcode, length, clocks for non-branch forms
  task automatic t_latency;
    logic [15:0] tab [24] = '{16'h2811, 16'h2522, 16'h2612, 16'hA311, 16'hA414, 16'h8418, 16'h5333, 16'hE411,
      16'hC411, 16'hD411, 16'h3311, 16'hF612, 16'h8533, 16'h8622, 16'h9033, 16'h9313, 16'h8313, 16'hE213,
      16'hF013, 16'hC022, 16'hD022, 16'hA511, 16'h6222, 16'hE811};
    int n, d;
    foreach (tab[i]) begin
      run(tab[i][15:8], 8'h30, 8'h40, 1'b0, n, d);
      chk("busy_clocks", tab[i][3:0], n);
      chk("done_clock", tab[i][3:0], d);
      chk("cycles_q", tab[i][3:0], instr_cycles_q);
      chk("length", tab[i][7:4], instr_len_q);
      chk("noop", tab[i][15:8] == 8'hA5, noop_q);
      chk("cond_flag", 1'b0, cond_branch_q);
      chk("next_addr", pc + tab[i][7:4], branch_target_q);
      pc = pc + tab[i][7:4];
    end
  endtask

  // Jumps with a backward offset, untaken then taken
  task automatic t_branch;
    logic [15:0] tab [3] = '{16'h6022, 16'h2033, 16'hB634};
    int n, d;
    for (int i = 0; i < 6; i++) begin
      run(tab[i/2][15:8], 8'hF0, 8'hF0, i[0], n, d);
      chk("branch_clocks", tab[i/2][3:0] + i[0], n);
      chk("taken", i[0], branch_taken_q);
      chk("cond_flag", 1'b1, cond_branch_q);
      chk("rel_flag", 1'b1, rel_valid_q);
      chk("target", pc + tab[i/2][7:4] - 16'h0010, branch_target_q);
      pc = pc + tab[i/2][7:4];
    end
  endtask

  // Last RAM address, then first register address
  task automatic t_direct;
    int n, d;
    for (int i = 0; i < 2; i++) begin
      run(8'h25, 8'h7F + i[7:0], 8'h00, 1'b0, n, d);
      chk("sfr_select", i[0], direct_is_sfr_q);
      chk("direct_addr", 16'h007F + i[15:0], direct_addr_q);
      pc = pc + 16'h0002;
    end
  endtask

  // Issue in the done clock, then a request held for the first three clocks of an eight-clock divide
  task automatic t_overlap;
    mem_i.mem[pc[7:0]] = 8'hE4;
    mem_i.mem[pc[7:0] + 8'h01] = 8'hA5;
    mem_i.mem[pc[7:0] + 8'h02] = 8'h84;
    fetch_pc = pc;
    fetch_valid = 1'b1;
    @(posedge clock);
    #1;
    fetch_pc = pc + 16'h0001;
    chk("ready_in_done", 1'b1, issue_ready);
    @(posedge clock);
    #1;
    fetch_pc = pc + 16'h0002;
    chk("spare_noop", 1'b1, noop_q);
    @(posedge clock);
    #1;
    fetch_pc = pc;
    repeat (3) @(posedge clock);
    #1;
    fetch_valid = 1'b0;
    chk("held_request", 4'h8, instr_cycles_q);
    repeat (8) @(posedge clock);
    #1;
    pc = pc + 16'h0003;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    #1;
    reset_n = 1'b1;
    chk("reset_ready", 1'b1, issue_ready);
    chk("reset_busy", 1'b0, instr_busy);
    t_latency();
    t_branch();
    t_direct();
    t_overlap();
    conclude();
  end
endmodule // tb_top

`default_nettype wire
